// [design/stac_defs.svh]
// timing counts, register offsets, field positions and reset values
`ifndef STAC_DEFS_SVH
`define STAC_DEFS_SVH

// clock and time unit of the duration registers
`define STAC_CLK_NS 50
`define STAC_UNIT_NS 1000
`define STAC_CYC_PER_UNIT (((`STAC_UNIT_NS) + (`STAC_CLK_NS) - 1) / (`STAC_CLK_NS))

// register byte offsets
`define STAC_OFF_CTRL 8'h00
`define STAC_OFF_CMD 8'h04
`define STAC_OFF_EXPO 8'h08
`define STAC_OFF_RATE 8'h0c
`define STAC_OFF_RDOUT 8'h10
`define STAC_OFF_XMIT 8'h14
`define STAC_OFF_STAT 8'h18

// control register fields
`define STAC_CTRL_SEL_ACQ 0
`define STAC_CTRL_TRIG_ON 1
`define STAC_CTRL_SRC_SW 2
`define STAC_CTRL_EXP_TIMED 3
`define STAC_CTRL_CONT 4
`define STAC_CTRL_RATE_LIM 5
`define STAC_CTRL_W 6

// command register fields
`define STAC_CMD_START 0
`define STAC_CMD_STOP 1
`define STAC_CMD_TRIG 2

// reset values
`define STAC_CTRL_RST 6'h00
`define STAC_EXPO_RST 16'h0064
`define STAC_RATE_RST 16'h0000
`define STAC_RDOUT_RST 16'h0010
`define STAC_XMIT_RST 16'h0020

`endif

// [design/stac_pkg.sv]
// types shared by the acquisition controller
package stac_pkg;
    // acquisition sequence, one-hot
    typedef enum logic [3:0] {
        STAC_IDLE = 4'b0001,
        STAC_EXPOSE = 4'b0010,
        STAC_READOUT = 4'b0100,
        STAC_XMIT = 4'b1000
    } stac_state_e;
    typedef logic [15:0] stac_dur_t;
    typedef logic [23:0] stac_cyc_t;
endpackage

// [design/stac_timer.sv]
// loadable down counter in clock cycles
`timescale 1ns/1ps
module stac_timer #(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    output logic busy_o,
    output logic last_o
);
    logic [W-1:0] cnt_reg;

    // load wins over counting
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
        end else if (load_i) begin
            cnt_reg <= value_i;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - W'(1);
        end
    end

    // last counted cycle
    assign busy_o = (cnt_reg != '0);
    assign last_o = (cnt_reg == W'(1));
endmodule // stac_timer

// [design/stac_ahb_port.sv]
// ahb-lite address phase capture, zero wait states
`timescale 1ns/1ps
module stac_ahb_port (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] waddr_o
);
    logic take;
    logic wr_reg;
    logic [7:0] waddr_reg;

    // word transfers in the low 256 bytes only
    assign take = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'h2) && (haddr_i[31:8] == 24'h000000);
    assign rd_o = take && !hwrite_i;

    // write lands in the data phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_reg <= 1'b0;
            waddr_reg <= 8'h00;
        end else begin
            wr_reg <= take && hwrite_i;
            if (take) begin
                waddr_reg <= haddr_i[7:0];
            end
        end
    end

    assign wr_o = wr_reg;
    assign waddr_o = waddr_reg;
endmodule // stac_ahb_port

// [design/stac_ctrl.sv]
// software-triggered acquisition controller with ahb-lite registers
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "stac_defs.svh"
module stac_ctrl (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic exposing_o,
    output logic readout_o,
    output logic transmit_o,
    output logic frame_done_o,
    output logic trigger_ready_o
);
    ////////////////////////////////////////////////////////////////
    // bus port and register file
    logic rd;
    logic wr;
    logic [7:0] waddr;
    logic [`STAC_CTRL_W-1:0] ctrl_reg;
    stac_pkg::stac_dur_t expo_reg;
    stac_pkg::stac_dur_t rate_reg;
    stac_pkg::stac_dur_t rdout_reg;
    stac_pkg::stac_dur_t xmit_reg;
    logic [15:0] frame_cnt_reg;
    logic [31:0] hrdata_reg;
    logic armed_reg;
    logic frame_done_reg;
    stac_pkg::stac_state_e state_reg;
    stac_pkg::stac_state_e state_next;

    stac_ahb_port u_port (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hready_i(hready_i),
        .rd_o(rd),
        .wr_o(wr),
        .waddr_o(waddr)
    );

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // configuration registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_reg <= `STAC_CTRL_RST;
            expo_reg <= `STAC_EXPO_RST;
            rate_reg <= `STAC_RATE_RST;
            rdout_reg <= `STAC_RDOUT_RST;
            xmit_reg <= `STAC_XMIT_RST;
        end else if (wr) begin
            case (waddr)
                `STAC_OFF_CTRL: ctrl_reg <= hwdata_i[`STAC_CTRL_W-1:0];
                `STAC_OFF_EXPO: expo_reg <= hwdata_i[15:0];
                `STAC_OFF_RATE: rate_reg <= hwdata_i[15:0];
                `STAC_OFF_RDOUT: rdout_reg <= hwdata_i[15:0];
                `STAC_OFF_XMIT: xmit_reg <= hwdata_i[15:0];
                default: ;
            endcase
        end
    end

    // command strobes, one cycle each
    logic cmd_wr;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_trig;
    assign cmd_wr = wr && (waddr == `STAC_OFF_CMD);
    assign cmd_start = cmd_wr && hwdata_i[`STAC_CMD_START];
    assign cmd_stop = cmd_wr && hwdata_i[`STAC_CMD_STOP];
    assign cmd_trig = cmd_wr && hwdata_i[`STAC_CMD_TRIG];

    ////////////////////////////////////////////////////////////////
    // trigger qualification
    logic cfg_ok;
    logic cont;
    logic rate_lim;
    logic rate_busy;
    logic idle;
    logic ready;
    logic accept;

    // software triggering only in the documented setup
    assign cfg_ok = ctrl_reg[`STAC_CTRL_SEL_ACQ] && ctrl_reg[`STAC_CTRL_TRIG_ON]
        && ctrl_reg[`STAC_CTRL_SRC_SW] && ctrl_reg[`STAC_CTRL_EXP_TIMED];
    assign cont = ctrl_reg[`STAC_CTRL_CONT];
    assign rate_lim = ctrl_reg[`STAC_CTRL_RATE_LIM];
    assign idle = (state_reg == stac_pkg::STAC_IDLE);
    assign ready = armed_reg && idle && cfg_ok && !(rate_lim && rate_busy);
    assign accept = cmd_trig && ready;
    assign trigger_ready_o = ready;

    // arming; stop wins over a start in the same write
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            armed_reg <= 1'b0;
        end else if (cmd_stop) begin
            armed_reg <= 1'b0;
        end else if (cmd_start) begin
            armed_reg <= 1'b1;
        end else if (accept && !cont) begin
            armed_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // phase and rate timers
    logic ph_last;
    logic ph_load;
    stac_pkg::stac_dur_t ph_dur;
    stac_pkg::stac_cyc_t ph_val;
    stac_pkg::stac_cyc_t rate_val;

    // duration of the phase being entered
    always_comb begin
        case (state_next)
            stac_pkg::STAC_EXPOSE: ph_dur = expo_reg;
            stac_pkg::STAC_READOUT: ph_dur = rdout_reg;
            default: ph_dur = xmit_reg;
        endcase
    end

    // a zero duration still takes one cycle
    assign ph_val = (ph_dur == 16'h0000) ? 24'h000001
        : {8'h00, ph_dur} * 24'(`STAC_CYC_PER_UNIT);
    assign rate_val = {8'h00, rate_reg} * 24'(`STAC_CYC_PER_UNIT);
    assign ph_load = (state_next != state_reg) && (state_next != stac_pkg::STAC_IDLE);

    stac_timer #(.W(24)) u_phase (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .load_i(ph_load),
        .value_i(ph_val),
        .busy_o(),
        .last_o(ph_last)
    );

    // minimum trigger spacing
    stac_timer #(.W(24)) u_rate (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .load_i(accept),
        .value_i(rate_val),
        .busy_o(rate_busy),
        .last_o()
    );

    ////////////////////////////////////////////////////////////////
    // acquisition sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            stac_pkg::STAC_IDLE: if (accept) state_next = stac_pkg::STAC_EXPOSE;
            stac_pkg::STAC_EXPOSE: if (ph_last) state_next = stac_pkg::STAC_READOUT;
            stac_pkg::STAC_READOUT: if (ph_last) state_next = stac_pkg::STAC_XMIT;
            stac_pkg::STAC_XMIT: if (ph_last) state_next = stac_pkg::STAC_IDLE;
            default: state_next = stac_pkg::STAC_IDLE;
        endcase
    end

    // state, frame counter and done pulse
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= stac_pkg::STAC_IDLE;
            frame_done_reg <= 1'b0;
            frame_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            frame_done_reg <= (state_reg == stac_pkg::STAC_XMIT) && ph_last;
            if ((state_reg == stac_pkg::STAC_XMIT) && ph_last) begin
                frame_cnt_reg <= frame_cnt_reg + 16'h0001;
            end
        end
    end

    assign exposing_o = (state_reg == stac_pkg::STAC_EXPOSE);
    assign readout_o = (state_reg == stac_pkg::STAC_READOUT);
    assign transmit_o = (state_reg == stac_pkg::STAC_XMIT);
    assign frame_done_o = frame_done_reg;

    ////////////////////////////////////////////////////////////////
    // read data, registered in the address phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd) begin
            case (haddr_i[7:0])
                `STAC_OFF_CTRL: hrdata_reg <= {26'h0, ctrl_reg};
                `STAC_OFF_EXPO: hrdata_reg <= {16'h0000, expo_reg};
                `STAC_OFF_RATE: hrdata_reg <= {16'h0000, rate_reg};
                `STAC_OFF_RDOUT: hrdata_reg <= {16'h0000, rdout_reg};
                `STAC_OFF_XMIT: hrdata_reg <= {16'h0000, xmit_reg};
                `STAC_OFF_STAT: hrdata_reg <= {frame_cnt_reg, 11'h000, ready,
                    transmit_o, readout_o, exposing_o, armed_reg};
                default: hrdata_reg <= 32'h00000000;
            endcase
        end
    end
    assign hrdata_o = hrdata_reg;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // helper: cycles spent in exposure and its load value
    logic [23:0] exp_cnt_reg;
    logic [23:0] exp_len_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            exp_cnt_reg <= 24'h000000;
            exp_len_reg <= 24'h000000;
        end else begin
            if (accept) begin
                exp_len_reg <= ph_val;
            end
            exp_cnt_reg <= exposing_o ? exp_cnt_reg + 24'h000001 : 24'h000000;
        end
    end

    property p_trig_starts;
        accept |=> exposing_o && !$past(exposing_o);
    endproperty
    a_trig_starts: assert property (p_trig_starts) else $error("trigger did not start exposure");

    property p_exp_len;
        exposing_o |-> (exp_cnt_reg < exp_len_reg);
    endproperty
    a_exp_len: assert property (p_exp_len) else $error("exposure ran too long");

    property p_exp_time;
        $fell(exposing_o) |-> ($past(exp_cnt_reg) + 24'h000001 == exp_len_reg);
    endproperty
    a_exp_time: assert property (p_exp_time) else $error("exposure length wrong");

    property p_single_arm;
        accept && !cont && !cmd_start |=> !armed_reg;
    endproperty
    a_single_arm: assert property (p_single_arm) else $error("single mode still armed");

    property p_readout_xmit;
        $fell(exposing_o) |-> readout_o ##1 (readout_o [*1] or transmit_o);
    endproperty
    a_readout_xmit: assert property (p_readout_xmit) else $error("no readout after exposure");

    property p_xmit_follows;
        $fell(readout_o) |-> transmit_o;
    endproperty
    a_xmit_follows: assert property (p_xmit_follows) else $error("no transmit after readout");

    property p_disarm_ignore;
        !armed_reg && cmd_trig && idle |=> idle && !exposing_o;
    endproperty
    a_disarm_ignore: assert property (p_disarm_ignore) else $error("disarmed trigger started capture");

    property p_cont_arm;
        accept && cont && !cmd_stop |=> armed_reg;
    endproperty
    a_cont_arm: assert property (p_cont_arm) else $error("continuous mode lost arm");

    property p_stop;
        cmd_stop |=> !armed_reg ##1 (!accept || $past(cmd_start));
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not disarm");

    property p_rate;
        accept && rate_lim && (rate_val > 24'h000000) |=> !accept [*1] ##0 rate_busy;
    endproperty
    a_rate: assert property (p_rate) else $error("rate cap not applied");

    property p_busy_drop;
        cmd_trig && !idle |=> $stable(armed_reg) || $past(cmd_stop) || $past(cmd_start);
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("busy trigger changed state");

    c_single: cover property (accept && !cont ##1 exposing_o);
    c_cont: cover property (accept && cont ##[1:1000] frame_done_o);
    c_dropped: cover property (cmd_trig && !ready);
    c_rate_hold: cover property (cmd_trig && rate_lim && rate_busy && idle && armed_reg);
endmodule // stac_ctrl

// [verif/stac_ctrl_tb.sv]
// self-checking bench for the software-triggered acquisition controller
`timescale 1ns/1ps
`include "stac_defs.svh"
module stac_ctrl_tb;
    logic clk, nrst_n, hsel, hwrite, hreadyout, hresp;
    logic exposing, readout, transmit, frame_done, trig_rdy;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic exp_prev, rd_prev;
    int n_errors, num_checks, seed, cyc, frames, nf;
    int exp_run, rd_run, tx_run, order_err, rise_prev, rise_last, expo, lo, gap;
    logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    logic [31:0] rsts [8] = '{32'h0, 32'h0, 32'h64, 32'h0, 32'h10, 32'h20, 32'h0, 32'h0};

    stac_ctrl stac_ctrl_inst (.clk_i(clk), .nrst_i(nrst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .exposing_o(exposing), .readout_o(readout), .transmit_o(transmit),
        .frame_done_o(frame_done), .trigger_ready_o(trig_rdy));

    ////////////////////////////////////////////////////////////////////////////
    // clock and cycle ceiling
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            wrap_up;
        end
    end

    // phase lengths, phase order, exposure start times, frames
    always @(negedge clk) begin
        if (exposing) exp_run++;
        if (readout) rd_run++;
        if (transmit) tx_run++;
        if (exp_prev && !exposing && !readout) order_err++;
        if (rd_prev && !readout && !transmit) order_err++;
        if (exposing && !exp_prev) begin
            rise_prev = rise_last;
            rise_last = cyc;
        end
        if (frame_done) frames++;
        exp_prev = exposing;
        rd_prev = readout;
    end

    ////////////////////////////////////////////////////////////////////////////
    // expected status word and minimum trigger spacing
    function automatic logic [31:0] stat_exp(input logic armed, input logic rdy, input int cnt);
        return {cnt[15:0], 11'h000, rdy, 3'b000, armed};
    endfunction

    function automatic int min_gap(input int rate, input int e);
        int nat;
        nat = (e + 2) * `STAC_CYC_PER_UNIT;
        return (rate * `STAC_CYC_PER_UNIT > nat) ? rate * `STAC_CYC_PER_UNIT : nat;
    endfunction

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite single transfers, entered just after a rising edge
    task automatic hwait;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        hsize <= 3'b010;
        hsel <= 1'b1;
        hwait;
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        hwait;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        hsize <= 3'b010;
        hsel <= 1'b1;
        hwait;
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwait;
        rdat = hrdata;
        chk_reg(rdat, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // waits and one triggered frame
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (trig_rdy !== 1'b1 && k < 3000);
    endtask

    // trigger, extra back-to-back triggers land during exposure
    task automatic shot(input int extra);
        int k;
        nf = frames;
        exp_run = 0;
        rd_run = 0;
        tx_run = 0;
        order_err = 0;
        ahb_write(`STAC_OFF_CMD, 32'h4);
        repeat (extra) ahb_write(`STAC_OFF_CMD, 32'h4);
        k = 0;
        while (frames == nf && k < 3000) begin
            @(posedge clk);
            k++;
        end
        idle(100);
        chk_cnt(frames, nf + 1); // one frame only
        chk_cnt(exp_run, expo * `STAC_CYC_PER_UNIT); // timed exposure
        chk_cnt(rd_run + tx_run, 2 * `STAC_CYC_PER_UNIT); // readout then transmit
        chk_cnt(order_err, 0); // phases in order
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        seed = 14;
        nrst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        exp_prev = 1'b0;
        rd_prev = 1'b0;
        repeat (2) @(posedge clk);
        nrst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rd_chk(offs[i], rsts[i]); // disarmed at reset
        chk_reg({31'h0, hresp}, 32'h0);
        $display("test reset done");

        // single frame: dropped when disarmed, one trigger per arming
        expo = ({$random(seed)} % 3) + 1;
        ahb_write(`STAC_OFF_EXPO, expo);
        ahb_write(`STAC_OFF_RDOUT, 32'h1);
        ahb_write(`STAC_OFF_XMIT, 32'h1);
        ahb_write(`STAC_OFF_CTRL, 32'h0f);
        ahb_write(`STAC_OFF_CMD, 32'h4);
        idle(100);
        chk_cnt(frames, 0); // disarmed trigger dropped
        ahb_write(`STAC_OFF_CMD, 32'h1);
        rd_chk(`STAC_OFF_STAT, stat_exp(1'b1, 1'b1, 0)); // armed by start
        shot(0);
        rd_chk(`STAC_OFF_STAT, stat_exp(1'b0, 1'b0, 1)); // one trigger disarms
        ahb_write(`STAC_OFF_CMD, 32'h4);
        idle(100);
        chk_cnt(frames, 1); // ignored until re-armed
        ahb_write(`STAC_OFF_CMD, 32'h1); // re-arm after transmit end
        shot(1); // re-armed capture
        $display("test single done");

        // any missing setting keeps triggers dropped
        for (int b = 0; b < 4; b++) begin
            ahb_write(`STAC_OFF_CTRL, 32'h0f ^ (32'h1 << b));
            ahb_write(`STAC_OFF_CMD, 32'h1);
            ahb_write(`STAC_OFF_CMD, 32'h4);
            idle(100);
            chk_cnt(frames, 2); // incomplete setup dropped
            ahb_write(`STAC_OFF_CMD, 32'h2);
        end
        $display("test setup done");

        // continuous: stays armed, busy triggers dropped, stop disarms
        ahb_write(`STAC_OFF_CTRL, 32'h1f);
        ahb_write(`STAC_OFF_CMD, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wait_ready; // poll ready
            shot({$random(seed)} % 3);
        end
        rd_chk(`STAC_OFF_STAT, stat_exp(1'b1, 1'b1, 5)); // still armed
        ahb_write(`STAC_OFF_CMD, 32'h2);
        ahb_write(`STAC_OFF_CMD, 32'h4);
        ahb_write(`STAC_OFF_CMD, 32'h3);
        ahb_write(`STAC_OFF_CMD, 32'h4);
        idle(100);
        chk_cnt(frames, 5); // stop wins and disarms
        rd_chk(`STAC_OFF_STAT, stat_exp(1'b0, 1'b0, 5)); // disarmed
        $display("test continuous done");

        // rate limit above and below the natural frame time, second trigger as soon as ready
        ahb_write(`STAC_OFF_CTRL, 32'h3f);
        ahb_write(`STAC_OFF_CMD, 32'h1);
        for (int r = 5; r > 0; r -= 4) begin
            ahb_write(`STAC_OFF_RATE, r);
            wait_ready; // poll ready
            shot(0);
            wait_ready; // poll ready
            ahb_write(`STAC_OFF_CMD, 32'h4); // first of a pair
            wait_ready; // poll ready
            shot(0);
            gap = rise_last - rise_prev;
            lo = min_gap(r, expo);
            chk_cnt(int'(gap >= lo && gap <= lo + 8), 1); // accepted spacing
        end
        $display("test rate done");
        wrap_up;
    end
endmodule // stac_ctrl_tb
